/* shared/sepwm_defines.svh */
// Sizes, encodings, reset values and timing counts of the event timer
`ifndef SEPWM_DEFINES_SVH
`define SEPWM_DEFINES_SVH
`define SEPWM_N_MR        8
`define SEPWM_N_EV        8
`define SEPWM_N_ST        8
`define SEPWM_N_IN        5
`define SEPWM_N_SEL_IN    4
`define SEPWM_N_SRC       8
`define SEPWM_N_OUT       6
`define SEPWM_CNT_W       32
`define SEPWM_HALF_W      16
`define SEPWM_CLK_MHZ     100
`define SEPWM_IN_FMAX_MHZ 25
`define SEPWM_IN_MIN_CYC  ((`SEPWM_CLK_MHZ + `SEPWM_IN_FMAX_MHZ - 1) / `SEPWM_IN_FMAX_MHZ)
`define SEPWM_CLKIN_IDX   3'h4
`define SEPWM_COND_LOW    2'h0
`define SEPWM_COND_RISE   2'h1
`define SEPWM_COND_FALL   2'h2
`define SEPWM_COND_HIGH   2'h3
`define SEPWM_COMB_OR     2'h0
`define SEPWM_COMB_MATCH  2'h1
`define SEPWM_COMB_IO     2'h2
`define SEPWM_COMB_AND    2'h3
`define SEPWM_DIR_ANY     2'h0
`define SEPWM_DIR_UP      2'h1
`define SEPWM_DIR_DOWN    2'h2
`define SEPWM_RST_CNT     32'h0000_0000
`define SEPWM_RST_STATE   3'h0
`endif

/* shared/sepwm_pkg.sv */
// Types shared by the event timer modules
package sepwm_pkg;
  typedef logic [2:0]  sepwm_state_t;
  typedef logic [31:0] sepwm_cnt_t;
  typedef logic [2:0]  sepwm_src_sel_t;
endpackage

/* shared/sepwm_in_if.sv */
// Carrier between input selector and timer core
`timescale 1ns/10ps
interface sepwm_in_if;
  sepwm_pkg::sepwm_src_sel_t [3:0] sel;
  logic                     [4:0] lvl;
  logic                     [4:0] rise;
  logic                     [4:0] fall;
  modport selector (input sel, output lvl, output rise, output fall);
  modport core     (output sel, input lvl, input rise, input fall);
endinterface

/* logic/sepwm_input_sel.sv */
// Timer input selectors with synchronisers and edge detection
`timescale 1ns/10ps
`include "sepwm_defines.svh"
module sepwm_input_sel (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [3:0] pin_in,
  input  wire logic       adc_thcmp_irq,
  input  wire logic       comp_out,
  input  wire logic       cpu_event_out,
  input  wire logic       core_a,
  input  wire logic       clk_src_in,
  sepwm_in_if.selector    sel_if
);
  logic [8:0] meta_r;
  logic [8:0] sync_r;
  logic [4:0] lvl_r;
  logic [4:0] prev_r;
  logic [7:0] src;

  // --------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------
  // Two flops on every source before any mux looks at it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_r <= 9'h000;
      sync_r <= 9'h000;
    end else begin
      meta_r <= {clk_src_in, core_a, cpu_event_out, comp_out, adc_thcmp_irq, pin_in};
      sync_r <= meta_r;
    end
  end

  assign src = sync_r[7:0];

  // --------------------------------------------------------------
  // Selection and edges
  // --------------------------------------------------------------
  // Four pins or four internal sources per input; fifth is the clock source
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lvl_r  <= 5'h00;
      prev_r <= 5'h00;
    end else begin
      for (int i = 0; i < `SEPWM_N_SEL_IN; i++) begin
        lvl_r[i] <= src[sel_if.sel[i]];
      end
      lvl_r[4] <= sync_r[8];
      prev_r   <= lvl_r;
    end
  end

  // Edges rely on inputs slower than a quarter of the system clock
  assign sel_if.lvl  = lvl_r;
  assign sel_if.rise = lvl_r & ~prev_r;
  assign sel_if.fall = ~lvl_r & prev_r;
endmodule

/* logic/sepwm_top.sv */
// State-sequenced event timer and PWM unit
`timescale 1ns/10ps
`include "sepwm_defines.svh"
module sepwm_top (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic [3:0]                    pin_in,
  input  wire logic                          adc_thcmp_irq,
  input  wire logic                          comp_out,
  input  wire logic                          cpu_event_out,
  input  wire logic                          core_a,
  input  wire logic                          clk_src_in,
  input  wire logic [3:0][2:0]               cfg_in_sel,
  input  wire logic                          cfg_unify,
  input  wire logic [1:0]                    cfg_clk_in,
  input  wire logic [1:0][2:0]               cfg_clk_in_idx,
  input  wire logic [1:0]                    cfg_bidir,
  input  wire logic [1:0]                    cfg_auto_limit,
  input  wire logic [1:0]                    sw_run,
  input  wire logic [2:0]                    cfg_adc_sel,
  input  wire logic [7:0]                    mr_capture,
  input  wire logic [7:0][31:0]              mr_value,
  input  wire logic [7:0][7:0]               mr_cap_ev,
  input  wire logic [7:0][7:0]               ev_state_mask,
  input  wire logic [7:0]                    ev_ctr_sel,
  input  wire logic [7:0][2:0]               ev_match_idx,
  input  wire logic [7:0][3:0]               ev_io_idx,
  input  wire logic [7:0][1:0]               ev_io_cond,
  input  wire logic [7:0][1:0]               ev_comb,
  input  wire logic [7:0][1:0]               ev_dir_qual,
  input  wire logic [7:0]                    ev_match_hold,
  input  wire logic [7:0]                    ev_act_limit,
  input  wire logic [7:0]                    ev_act_halt,
  input  wire logic [7:0]                    ev_act_stop,
  input  wire logic [7:0]                    ev_act_start,
  input  wire logic [7:0]                    ev_act_reverse,
  input  wire logic [7:0]                    ev_state_ld,
  input  wire logic [7:0][2:0]               ev_state_nxt,
  input  wire logic [7:0][5:0]               ev_out_set,
  input  wire logic [7:0][5:0]               ev_out_clr,
  input  wire logic [7:0]                    ev_irq_en,
  input  wire logic [7:0]                    ev_dma_en,
  output logic      [1:0][31:0]              count,
  output sepwm_pkg::sepwm_state_t [1:0]      state,
  output logic      [1:0]                    dir_down,
  output logic      [1:0]                    halted,
  output logic      [7:0][31:0]              cap_value,
  output logic      [7:0]                    ev_fire,
  output logic                               irq_req,
  output logic                               dma_req,
  output logic      [5:0]                    pwm_out,
  output logic                               adc_trig
);
  sepwm_in_if in_if ();

  sepwm_pkg::sepwm_cnt_t   [1:0] cnt_r;
  sepwm_pkg::sepwm_state_t [1:0] state_r;
  logic [1:0]      dir_r;
  logic [1:0]      halt_r;
  logic [1:0]      stop_r;
  logic [1:0]      fresh_r;
  logic [7:0]      held_r;
  logic [7:0]      fire_r;
  logic [5:0]      out_r;
  logic [5:0]      out_prev_r;
  logic            irq_r;
  logic            dma_r;
  logic            adc_r;
  logic [1:0][7:0] hit;
  logic [7:0]      fire;
  logic [1:0]      tick;
  logic [1:0]      lim_ev;
  logic [1:0]      halt_ev;
  logic [1:0]      stop_ev;
  logic [1:0]      start_ev;
  logic [1:0]      rev_ev;
  logic [1:0]      st_ld;
  sepwm_pkg::sepwm_state_t [1:0] st_nxt;

  // ----------------------------------------------------------------
  // Input selection
  // ----------------------------------------------------------------
  assign in_if.sel = cfg_in_sel;

  sepwm_input_sel u_sel (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .pin_in        (pin_in),
    .adc_thcmp_irq (adc_thcmp_irq),
    .comp_out      (comp_out),
    .cpu_event_out (cpu_event_out),
    .core_a        (core_a),
    .clk_src_in    (clk_src_in),
    .sel_if        (in_if)
  );

  // ----------------------------------------------------------------
  // Match detection
  // ----------------------------------------------------------------
  // Match only on the first cycle a counter shows a new value
  genvar c, m, e;
  generate
    for (c = 0; c < 2; c++) begin : g_hit
      for (m = 0; m < `SEPWM_N_MR; m++) begin : g_mr
        logic eq;
        always_comb begin
          if (cfg_unify) begin
            eq = (c == 0) && (cnt_r[0] == mr_value[m]);
          end else if (c == 0) begin
            eq = cnt_r[0][15:0] == mr_value[m][15:0];
          end else begin
            eq = cnt_r[1][15:0] == mr_value[m][31:16];
          end
        end
        assign hit[c][m] = eq && !mr_capture[m] && fresh_r[c];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event evaluation
  // ----------------------------------------------------------------
  generate
    for (e = 0; e < `SEPWM_N_EV; e++) begin : g_ev
      logic ec;
      logic mt;
      logic io_lvl;
      logic io_r;
      logic io_f;
      logic io_t;
      logic dir_ok;
      always_comb begin
        ec = cfg_unify ? 1'b0 : ev_ctr_sel[e];
        mt = hit[ec][ev_match_idx[e]] || (ev_match_hold[e] && held_r[e]);
        if (ev_io_idx[e][3]) begin
          io_lvl = out_r[ev_io_idx[e][2:0]];
          io_r   = out_r[ev_io_idx[e][2:0]] && !out_prev_r[ev_io_idx[e][2:0]];
          io_f   = !out_r[ev_io_idx[e][2:0]] && out_prev_r[ev_io_idx[e][2:0]];
        end else begin
          io_lvl = in_if.lvl[ev_io_idx[e][2:0]];
          io_r   = in_if.rise[ev_io_idx[e][2:0]];
          io_f   = in_if.fall[ev_io_idx[e][2:0]];
        end
        case (ev_io_cond[e])
          `SEPWM_COND_LOW:  io_t = !io_lvl;
          `SEPWM_COND_RISE: io_t = io_r;
          `SEPWM_COND_FALL: io_t = io_f;
          default:          io_t = io_lvl;
        endcase
        case (ev_dir_qual[e])
          `SEPWM_DIR_UP:   dir_ok = !cfg_bidir[ec] || !dir_r[ec];
          `SEPWM_DIR_DOWN: dir_ok = cfg_bidir[ec] && dir_r[ec];
          default:         dir_ok = 1'b1;
        endcase
        case (ev_comb[e])
          `SEPWM_COMB_OR:    fire[e] = mt || io_t;
          `SEPWM_COMB_MATCH: fire[e] = mt;
          `SEPWM_COMB_IO:    fire[e] = io_t;
          default:           fire[e] = mt && io_t;
        endcase
        fire[e] = fire[e] && dir_ok && !halt_r[ec]
                  && ev_state_mask[e][state_r[ec]];
      end

      // Pending match kept until its event fires; a new match wins
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          held_r[e] <= 1'b0;
        end else if (hit[ec][ev_match_idx[e]]) begin
          held_r[e] <= ev_match_hold[e];
        end else if (fire[e]) begin
          held_r[e] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event actions gathered per counter
  // ----------------------------------------------------------------
  // Highest-numbered firing event that loads state decides the next state
  always_comb begin
    lim_ev   = 2'h0;
    halt_ev  = 2'h0;
    stop_ev  = 2'h0;
    start_ev = 2'h0;
    rev_ev   = 2'h0;
    st_ld    = 2'h0;
    st_nxt   = state_r;
    for (int i = 0; i < `SEPWM_N_EV; i++) begin
      if (fire[i]) begin
        automatic int k = cfg_unify ? 0 : int'(ev_ctr_sel[i]);
        lim_ev[k]   = lim_ev[k] | ev_act_limit[i];
        halt_ev[k]  = halt_ev[k] | ev_act_halt[i];
        stop_ev[k]  = stop_ev[k] | ev_act_stop[i];
        start_ev[k] = start_ev[k] | ev_act_start[i];
        rev_ev[k]   = rev_ev[k] | ev_act_reverse[i];
        if (ev_state_ld[i]) begin
          st_ld[k]  = 1'b1;
          st_nxt[k] = ev_state_nxt[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  generate
    for (c = 0; c < 2; c++) begin : g_cnt
      logic lim;
      logic run;
      sepwm_pkg::sepwm_cnt_t up_v;
      sepwm_pkg::sepwm_cnt_t dn_v;
      always_comb begin
        tick[c] = cfg_clk_in[c] ? in_if.rise[cfg_clk_in_idx[c]] : 1'b1;
        run     = tick[c] && !halt_r[c] && !stop_r[c] && !(c == 1 && cfg_unify);
        lim     = (cfg_auto_limit[c] && hit[c][0]) || lim_ev[c];
        if (cfg_unify) begin
          up_v = cnt_r[c] + 32'h1;
          dn_v = cnt_r[c] - 32'h1;
        end else begin
          up_v = {16'h0, cnt_r[c][15:0] + 16'h1};
          dn_v = {16'h0, cnt_r[c][15:0] - 16'h1};
        end
      end

      // Count, wrap at limit, or turn round in up-down mode
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          cnt_r[c]   <= `SEPWM_RST_CNT;
          dir_r[c]   <= 1'b0;
          fresh_r[c] <= 1'b1;
        end else begin
          fresh_r[c] <= run;
          if (run) begin
            if (!cfg_bidir[c]) begin
              cnt_r[c] <= lim ? `SEPWM_RST_CNT : up_v;
              dir_r[c] <= 1'b0;
            end else if (!dir_r[c]) begin
              cnt_r[c] <= (lim || rev_ev[c]) ? dn_v : up_v;
              dir_r[c] <= lim || rev_ev[c];
            end else if (cnt_r[c] == `SEPWM_RST_CNT || rev_ev[c]) begin
              cnt_r[c] <= up_v;
              dir_r[c] <= 1'b0;
            end else begin
              cnt_r[c] <= dn_v;
            end
          end else if (rev_ev[c] && cfg_bidir[c]) begin
            dir_r[c] <= !dir_r[c];
          end
        end
      end

      // Halt needs software to release; stop is undone by a start event
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          halt_r[c] <= 1'b1;
          stop_r[c] <= 1'b0;
        end else begin
          if (halt_ev[c]) begin
            halt_r[c] <= 1'b1;
          end else if (sw_run[c]) begin
            halt_r[c] <= 1'b0;
          end
          if (stop_ev[c]) begin
            stop_r[c] <= 1'b1;
          end else if (start_ev[c]) begin
            stop_r[c] <= 1'b0;
          end
        end
      end

      // State only changes through events, never on wrap or limit
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          state_r[c] <= `SEPWM_RST_STATE;
        end else if (st_ld[c]) begin
          state_r[c] <= st_nxt[c];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Capture registers
  // ----------------------------------------------------------------
  generate
    for (m = 0; m < `SEPWM_N_MR; m++) begin : g_cap
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          cap_value[m] <= `SEPWM_RST_CNT;
        end else if (mr_capture[m] && |(fire & mr_cap_ev[m])) begin
          cap_value[m] <= cfg_unify ? cnt_r[0]
                          : {cnt_r[1][15:0], cnt_r[0][15:0]};
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs, requests and converter trigger
  // ----------------------------------------------------------------
  // Set and clear together toggle the output
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_r      <= 6'h00;
      out_prev_r <= 6'h00;
    end else begin
      out_prev_r <= out_r;
      for (int o = 0; o < `SEPWM_N_OUT; o++) begin
        automatic logic s = 1'b0;
        automatic logic r = 1'b0;
        for (int i = 0; i < `SEPWM_N_EV; i++) begin
          s = s | (fire[i] & ev_out_set[i][o]);
          r = r | (fire[i] & ev_out_clr[i][o]);
        end
        if (s && r) begin
          out_r[o] <= !out_r[o];
        end else if (s) begin
          out_r[o] <= 1'b1;
        end else if (r) begin
          out_r[o] <= 1'b0;
        end
      end
    end
  end

  // Requests are registered ORs of the enabled firing events, high in the cycle after an enabled event fires
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fire_r <= 8'h00;
      irq_r  <= 1'b0;
      dma_r  <= 1'b0;
      adc_r  <= 1'b0;
    end else begin
      fire_r <= fire;
      irq_r  <= |(fire & ev_irq_en);
      dma_r  <= |(fire & ev_dma_en);
      adc_r  <= (cfg_adc_sel < 3'h6) ? out_r[cfg_adc_sel] : 1'b0;
    end
  end

  assign count    = cnt_r;
  assign state    = state_r;
  assign dir_down = dir_r;
  assign halted   = halt_r;
  assign ev_fire  = fire_r;
  assign irq_req  = irq_r;
  assign dma_req  = dma_r;
  assign pwm_out  = out_r;
  assign adc_trig = adc_r;
endmodule

/* verif/sepwm_src_model.sv */
// Model of the on-chip sources and pins that feed the timer inputs
`timescale 1ns/10ps
module sepwm_src_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  output logic      [3:0] pin_in,
  output logic            adc_thcmp_irq,
  output logic            comp_out,
  output logic            cpu_event_out,
  output logic            core_a,
  output logic            clk_src_in
);
  logic [7:0] n_r;

  // Free-running pattern, moved on the falling edge away from sampling
  always @(negedge clk_sys or posedge reset) begin
    if (reset) begin
      n_r <= 8'h00;
    end else begin
      n_r <= n_r + 8'h01;
    end
  end

  // Clock source toggles every two cycles: 25 MHz at most
  assign clk_src_in    = n_r[1];
  assign cpu_event_out = n_r[3];
  assign pin_in        = n_r[7:4];
  assign comp_out      = n_r[4];
  assign adc_thcmp_irq = n_r[5];
  assign core_a        = n_r[6];
endmodule

/* verif/sepwm_props.sv */
// Concurrent checks on the event timer top ports
`timescale 1ns/10ps
module sepwm_props (
  input wire logic                          clk_sys,
  input wire logic                          reset,
  input wire logic                          cfg_unify,
  input wire logic [1:0]                    cfg_clk_in,
  input wire logic [1:0]                    cfg_bidir,
  input wire logic [1:0]                    cfg_auto_limit,
  input wire logic [1:0]                    sw_run,
  input wire logic [2:0]                    cfg_adc_sel,
  input wire logic [7:0][31:0]              mr_value,
  input wire logic [7:0]                    ev_act_halt,
  input wire logic [7:0]                    ev_state_ld,
  input wire logic [7:0]                    ev_irq_en,
  input wire logic [7:0]                    ev_dma_en,
  input wire logic [1:0][31:0]              count,
  input wire sepwm_pkg::sepwm_state_t [1:0] state,
  input wire logic [1:0]                    halted,
  input wire logic [7:0]                    ev_fire,
  input wire logic                          irq_req,
  input wire logic                          dma_req,
  input wire logic [5:0]                    pwm_out,
  input wire logic                          adc_trig
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Release of halt by software on a system-clock counter
  sequence s_run;
    sw_run[0] && halted[0] && !cfg_clk_in[0];
  endsequence
  sequence s_moving;
    !halted[0] ##1 count[0] != $past(count[0]);
  endsequence

  chk_run_release: assert property (s_run |=> s_moving)
    else $error("counter did not start after run request");
  chk_halt_hold: assert property (halted[0] |=> $stable(count[0]))
    else $error("halted counter moved");
  chk_up_wrap: assert property (!$past(halted[0]) && !halted[0] && cfg_unify && !cfg_bidir[0]
    && !cfg_clk_in[0] && cfg_auto_limit[0]
    |-> count[0] == (($past(count[0]) == $past(mr_value[0])) ? 32'h0 : $past(count[0]) + 32'h1))
    else $error("up count or limit wrap wrong");
  chk_adc_follow: assert property ($past(cfg_adc_sel) < 3'h6 |-> adc_trig == $past(pwm_out[cfg_adc_sel]))
    else $error("converter trigger does not follow output");
  chk_irq_cause: assert property (irq_req == |(ev_fire & $past(ev_irq_en)))
    else $error("interrupt request without matching event");
  chk_dma_cause: assert property (dma_req == |(ev_fire & $past(ev_dma_en)))
    else $error("dma request without matching event");
  chk_state_cause: assert property (!$stable(state[0]) |-> |(ev_fire & $past(ev_state_ld)))
    else $error("state moved without loading event");
  chk_pwm_cause: assert property (!$stable(pwm_out) |-> |ev_fire)
    else $error("output moved without event");
  chk_halt_event: assert property ($past(cfg_unify) && |(ev_fire & $past(ev_act_halt)) |-> halted[0])
    else $error("halt event did not halt counter");
endmodule

bind sepwm_top sepwm_props i_sepwm_props (.clk_sys, .reset, .cfg_unify, .cfg_clk_in, .cfg_bidir, .cfg_auto_limit,
  .sw_run, .cfg_adc_sel, .mr_value, .ev_act_halt, .ev_state_ld, .ev_irq_en, .ev_dma_en, .count, .state, .halted,
  .ev_fire, .irq_req, .dma_req, .pwm_out, .adc_trig);

/* verif/tb_top.sv */
// Self-checking testbench of the event timer
`timescale 1ns/10ps
module tb_top;
  logic                 clk_sys, reset, cfg_unify, adc_thcmp_irq, comp_out, cpu_event_out, core_a, clk_src_in;
  logic                 irq_req, dma_req, adc_trig;
  logic [3:0]           pin_in;
  logic [1:0]           cfg_clk_in, cfg_bidir, cfg_auto_limit, sw_run, dir_down, halted;
  logic [2:0]           cfg_adc_sel;
  logic [7:0]           mr_capture, ev_ctr_sel, ev_match_hold, ev_act_limit, ev_act_halt, ev_act_stop, ev_act_start;
  logic [7:0]           ev_act_reverse, ev_state_ld, ev_irq_en, ev_dma_en, ev_fire;
  logic [5:0]           pwm_out;
  logic [3:0][2:0]      cfg_in_sel;
  logic [1:0][2:0]      cfg_clk_in_idx;
  logic [7:0][31:0]     mr_value, cap_value;
  logic [7:0][7:0]      mr_cap_ev, ev_state_mask;
  logic [7:0][2:0]      ev_match_idx, ev_state_nxt;
  logic [7:0][3:0]      ev_io_idx;
  logic [7:0][1:0]      ev_io_cond, ev_comb, ev_dir_qual;
  logic [7:0][5:0]      ev_out_set, ev_out_clr;
  logic [1:0][31:0]     count;
  sepwm_pkg::sepwm_state_t [1:0] state;
  int                   n_errors, checked, hi, lo, n;
  logic [31:0]          c;

  sepwm_top i_sepwm_top (.clk_sys, .reset, .pin_in, .adc_thcmp_irq, .comp_out, .cpu_event_out, .core_a,
    .clk_src_in, .cfg_in_sel, .cfg_unify, .cfg_clk_in, .cfg_clk_in_idx, .cfg_bidir, .cfg_auto_limit, .sw_run,
    .cfg_adc_sel, .mr_capture, .mr_value, .mr_cap_ev, .ev_state_mask, .ev_ctr_sel, .ev_match_idx, .ev_io_idx,
    .ev_io_cond, .ev_comb, .ev_dir_qual, .ev_match_hold, .ev_act_limit, .ev_act_halt, .ev_act_stop, .ev_act_start,
    .ev_act_reverse, .ev_state_ld, .ev_state_nxt, .ev_out_set, .ev_out_clr, .ev_irq_en, .ev_dma_en, .count,
    .state, .dir_down, .halted, .cap_value, .ev_fire, .irq_req, .dma_req, .pwm_out, .adc_trig);
  sepwm_src_model i_sepwm_src_model (.clk_sys, .reset, .pin_in, .adc_thcmp_irq, .comp_out, .cpu_event_out,
    .core_a, .clk_src_in);

  // Clock at 100 MHz
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Reset held four cycles with all configuration cleared
  task automatic do_reset;
    reset = 1'b1;
    {cfg_unify, cfg_clk_in, cfg_bidir, cfg_auto_limit, sw_run, cfg_adc_sel, mr_capture, ev_ctr_sel, ev_match_hold,
     ev_act_limit, ev_act_halt, ev_act_stop, ev_act_start, ev_act_reverse, ev_state_ld, ev_irq_en, ev_dma_en,
     cfg_in_sel, cfg_clk_in_idx, mr_value, mr_cap_ev, ev_state_mask, ev_match_idx, ev_state_nxt, ev_io_idx,
     ev_io_cond, ev_comb, ev_dir_qual, ev_out_set, ev_out_clr} = '0;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
  endtask

  // One-cycle run pulse for the selected counters
  task automatic run(input logic [1:0] m);
    sw_run = m;
    @(negedge clk_sys);
    sw_run = 2'b00;
  endtask

  // Cycles spent by output 0 at one level, bounded
  task automatic meas(input logic lv, output int k);
    k = 0;
    while (pwm_out[0] === lv && k < 60) begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    do_reset();
    chk(halted, 2'b11);
    chk(count[0], 32'h0);
    chk(count[1], 32'h0);
    chk(state, 6'h0);
    chk({pwm_out, ev_fire, adc_trig}, 0);
    $display("test reset done");
  endtask

  // PWM with limit, capture, state load, then a halt in the new state
  task automatic t_pwm;
    do_reset();
    cfg_unify = 1'b1;
    cfg_auto_limit = 2'b01;
    mr_value[0] = 32'h9;
    mr_value[1] = 32'h3;
    ev_state_mask[0] = 8'hff;
    ev_state_mask[1] = 8'hff;
    ev_comb = {8{2'h1}};
    ev_match_idx[1] = 3'h1;
    ev_out_set[0] = 6'h01;
    ev_out_clr[1] = 6'h01;
    ev_irq_en = 8'h01;
    ev_state_ld = 8'h01;
    ev_state_nxt[0] = 3'h3;
    mr_capture = 8'h04;
    mr_cap_ev[2] = 8'h01;
    run(2'b01);
    meas(1'b0, n);
    meas(1'b1, hi);
    meas(1'b0, lo);
    chk(hi, 4);
    chk(hi + lo, 10);
    chk(cap_value[2], 32'h9);
    chk(state[0], 3'h3);
    chk(count[1], 32'h0);
    ev_match_idx[2] = 3'h1;
    ev_state_mask[2] = 8'h08;
    ev_act_halt = 8'h04;
    n = 0;
    while (halted[0] !== 1'b1 && n < 30) begin
      @(negedge clk_sys);
      n++;
    end
    c = count[0];
    repeat (5) @(negedge clk_sys);
    chk(halted[0], 1'b1);
    chk(count[0], c);
    $display("test pwm done");
  endtask

  // Counter ticking on the clock-source input
  task automatic t_clkin;
    do_reset();
    cfg_unify = 1'b1;
    cfg_clk_in = 2'b01;
    cfg_clk_in_idx[0] = 3'h4;
    run(2'b01);
    repeat (40) @(negedge clk_sys);
    chk(count[0] >= 32'h7 && count[0] <= 32'ha, 1'b1);
    $display("test input clock done");
  endtask

  // Two half counters plus an event on a selected internal source
  task automatic t_split;
    do_reset();
    cfg_in_sel[0] = 3'h6;
    ev_io_cond[3] = 2'h1;
    ev_comb[3] = 2'h2;
    ev_state_mask[3] = 8'hff;
    ev_dma_en = 8'h08;
    run(2'b11);
    n = 0;
    repeat (64) begin
      @(negedge clk_sys);
      n += int'(dma_req === 1'b1);
    end
    chk(count[0], 32'h40);
    chk(count[1], count[0]);
    chk(n >= 3 && n <= 5, 1'b1);
    $display("test split done");
  endtask

  // Up-down counting with limit 4 and a down-only event on match 1
  task automatic t_bidir;
    do_reset();
    cfg_unify = 1'b1;
    cfg_bidir = 2'b01;
    cfg_auto_limit = 2'b01;
    mr_value[0] = 32'h4;
    mr_value[1] = 32'h2;
    ev_state_mask[0] = 8'hff;
    ev_comb[0] = 2'h1;
    ev_match_idx[0] = 3'h1;
    ev_dir_qual[0] = 2'h2;
    ev_out_set[0] = 6'h01;
    run(2'b01);
    repeat (5) @(negedge clk_sys);
    chk(count[0], 32'h3);
    chk(dir_down[0], 1'b1);
    chk(pwm_out[0], 1'b0);
    repeat (4) @(negedge clk_sys);
    chk(count[0], 32'h1);
    chk(dir_down[0], 1'b0);
    chk(pwm_out[0], 1'b1);
    $display("test bidir done");
  endtask

  task automatic end_of_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end

  initial begin
    n_errors = 0;
    checked = 0;
    do_reset();
    t_reset();
    t_pwm();
    t_clkin();
    t_split();
    t_bidir();
    end_of_test();
  end
endmodule
